// *** verilog/rst_mgr_pkg.sv ***
// constants for the reset manager: register map, fields, codes, states
// assumes one clock (the slow clock) and a plain register port
//
// What this block does
// - three active-low resets: processor, peripherals, pin
// - everything runs on the single slow clock
// - state manager requests pin pulses from pin manager
// - power-up pulses pin, then holds while low
// - sampled low pin level reports a user reset
// - user enable cleared: pin low resets nothing
// - status shows current pin level anytime
// - sticky fall flag, cleared by status read
// - irq enable: pin fall interrupts instead
// - pin pulse lasts 2^(len+1) cycles
// - mode register survives all but general reset
// - cause field updates when processor reset releases
// - general reset: mode to reset values, pin rises later
// - backup wake records backup cause
// - user reset asserts processor and peripheral immediately
// - pin input synchronised before use
// - user reset ends after resync plus startup
// - user reset release loads cause 0x4
// - pin held at least pulse length
// - internal resets held while pin stays low, in power-up and user resets only
// - command taken only with key 0xa5
// - software reset lasts three cycles
// - watchdog reset lasts three cycles
// - priority: general, backup, watchdog, software, user
package rst_mgr_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_CMD  = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_MODE = 4'h8;
  // command fields
  localparam int         KEY_LSB   = 24;
  localparam logic [7:0] CMD_KEY   = 8'ha5;
  localparam int         C_PROC    = 0;
  localparam int         C_PERI    = 2;
  localparam int         C_EXT     = 3;
  // status fields
  localparam int         S_FALL    = 0;
  localparam int         S_CAUSE   = 8;
  localparam int         S_LEVEL   = 16;
  localparam int         S_BUSY    = 17;
  // mode fields and reset values
  localparam int         M_UEN     = 0;
  localparam int         M_IEN     = 4;
  localparam int         M_LEN     = 8;
  localparam logic       UEN_RST   = 1'b1;
  localparam logic       IEN_RST   = 1'b0;
  localparam logic [3:0] LEN_RST   = 4'h0;
  // timing in slow-clock cycles, pulse counter width in bits
  localparam logic [1:0] HOLD_LAST = 2'h2;
  localparam int         PW        = 17;
  // last reset cause codes
  localparam logic [2:0] CA_GEN    = 3'h0;
  localparam logic [2:0] CA_BKUP   = 3'h1;
  localparam logic [2:0] CA_WDT    = 3'h2;
  localparam logic [2:0] CA_SW     = 3'h3;
  localparam logic [2:0] CA_USER   = 3'h4;
  // reset state manager states
  typedef enum logic [5:0] {
    st_idle = 6'h01,
    st_gen  = 6'h02,
    st_bkup = 6'h04,
    st_wdt  = 6'h08,
    st_sw   = 6'h10,
    st_user = 6'h20
  } state_t;
endpackage

// *** verilog/system_reset_manager.sv ***
// reset state manager and pin manager in one module
// assumes mclk is the slow clock and rst_b is the general supply reset
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module system_reset_manager (
  // clock and general reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  // supply controller and watchdog
  input  wire logic        backup_wake,
  input  wire logic        wdt_fault,
  input  wire logic        wdt_proc_only,
  // external reset pin
  input  wire logic        nrst_i,
  output logic             nrst_o,
  output logic             nrst_oe,
  // reset outputs
  output logic             proc_rst_b,
  output logic             periph_rst_b,
  output logic             proc_clk_en,
  output logic             user_irq
);

  ////////////////////////////////////////////////////////////////
  // declarations
  rst_mgr_pkg::state_t state_q;  // current reset state
  rst_mgr_pkg::state_t state_d;  // next reset state
  logic [1:0]    cnt_q;          // cycles spent in state
  logic [rst_mgr_pkg::PW-1:0] pulse_q; // pin pulse countdown
  logic          oe_q;           // pin driven low
  logic          self_q;         // low level is our own pulse
  logic          s1_q;           // pin sync stage one
  logic          s2_q;           // pin sync stage two
  logic          s3_q;           // previous synced level
  logic          fall_q;         // sticky fall flag
  logic          uen_q;          // user reset enable
  logic          ien_q;          // user interrupt enable
  logic [3:0]    len_q;          // pulse length select
  logic [2:0]    cause_q;        // last reset cause
  logic [2:0]    sw_q;           // software command bits
  logic [2:0]    sw_d;
  logic          wpo_q;          // watchdog processor only
  logic          wpo_d;
  logic          proc_q;
  logic          peri_q;
  logic          clk_en_q;
  logic          irq_q;
  logic          pin_o_q;
  logic [31:0]   rdata_q;
  logic          ext_req;        // pin pulse request
  logic          hold;           // user reset waiting for pin
  logic          sw_ok;
  logic          user_req;
  logic          done;
  logic          rd_stat;

  ////////////////////////////////////////////////////////////////
  // functions
  // last count of a pin pulse
  function automatic logic [rst_mgr_pkg::PW-1:0] pulse_top(
    input logic [3:0] len
  );
    logic [4:0] sh;
    sh = {1'b0, len} + 5'h01;
    pulse_top = (rst_mgr_pkg::PW'(1) << sh) - rst_mgr_pkg::PW'(1);
  endfunction

  // processor reset asserted in a state
  function automatic logic proc_on(
    input rst_mgr_pkg::state_t st,
    input logic                swp
  );
    proc_on = (st == rst_mgr_pkg::st_sw) ? swp : (st != rst_mgr_pkg::st_idle);
  endfunction

  // peripheral reset asserted in a state
  function automatic logic peri_on(
    input rst_mgr_pkg::state_t st,
    input logic [2:0]          swb,
    input logic                wpo
  );
    unique case (st)
      rst_mgr_pkg::st_idle: peri_on = 1'b0;
      rst_mgr_pkg::st_sw:   peri_on = swb[1];
      rst_mgr_pkg::st_wdt:  peri_on = !wpo;
      default:              peri_on = 1'b1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // request decoding
  assign rd_stat = rd_en && (addr == rst_mgr_pkg::ADDR_STAT);
  // keyed command with at least one bit, idle only
  assign sw_ok = wr_en && (addr == rst_mgr_pkg::ADDR_CMD)
              && (wdata[rst_mgr_pkg::KEY_LSB +: 8] == rst_mgr_pkg::CMD_KEY)
              && (wdata[rst_mgr_pkg::C_PROC] || wdata[rst_mgr_pkg::C_PERI]
                  || wdata[rst_mgr_pkg::C_EXT]);
  // low synced pin not caused by our own pulse
  assign user_req = !s2_q && uen_q && !self_q && !oe_q;
  // pin low or still driven keeps user reset waiting
  assign hold = (state_q == rst_mgr_pkg::st_user) && (oe_q || !s2_q);
  assign done = (cnt_q == rst_mgr_pkg::HOLD_LAST);

  ////////////////////////////////////////////////////////////////
  // next state, priority resolution
  always_comb
  begin
    state_d = state_q;
    ext_req = 1'b0;
    sw_d    = sw_q;
    wpo_d   = wpo_q;
    // backup outranks all but general
    if (backup_wake && (state_q != rst_mgr_pkg::st_bkup)
        && (state_q != rst_mgr_pkg::st_gen))
    begin
      state_d = rst_mgr_pkg::st_bkup;
    end
    else
    begin
      unique case (state_q)
        // idle: watchdog, then software, then user
        rst_mgr_pkg::st_idle:
        begin
          if (wdt_fault)
          begin
            state_d = rst_mgr_pkg::st_wdt;
            wpo_d   = wdt_proc_only;
            ext_req = !wdt_proc_only;
          end
          else if (sw_ok)
          begin
            state_d = rst_mgr_pkg::st_sw;
            sw_d    = {wdata[rst_mgr_pkg::C_EXT], wdata[rst_mgr_pkg::C_PERI],
                       wdata[rst_mgr_pkg::C_PROC]};
            ext_req = wdata[rst_mgr_pkg::C_EXT];
          end
          else if (user_req)
          begin
            state_d = rst_mgr_pkg::st_user;
            ext_req = 1'b1;
          end
        end
        // power-up: leave once pulse over and pin high
        rst_mgr_pkg::st_gen:
        begin
          if (!oe_q && s2_q)
          begin
            state_d = rst_mgr_pkg::st_idle;
          end
        end
        // watchdog preempts a software reset
        rst_mgr_pkg::st_sw:
        begin
          if (wdt_fault)
          begin
            state_d = rst_mgr_pkg::st_wdt;
            wpo_d   = wdt_proc_only;
            ext_req = !wdt_proc_only;
          end
          else if (done)
          begin
            state_d = rst_mgr_pkg::st_idle;
          end
        end
        // user: pin high, then startup count
        rst_mgr_pkg::st_user:
        begin
          if (!hold && done)
          begin
            state_d = rst_mgr_pkg::st_idle;
          end
        end
        // fixed-length states
        default:
        begin
          if (done)
          begin
            state_d = rst_mgr_pkg::st_idle;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // state register and command latches
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state_q <= rst_mgr_pkg::st_gen;
      sw_q    <= 3'h0;
      wpo_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      sw_q    <= sw_d;
      wpo_q   <= wpo_d;
    end
  end

  // cycles in state, restarted on entry and while waiting
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      cnt_q <= 2'h0;
    end
    else if ((state_d != state_q) || hold)
    begin
      cnt_q <= 2'h0;
    end
    else if (!done)
    begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // reset outputs follow the next state
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      proc_q   <= 1'b0;
      peri_q   <= 1'b0;
      clk_en_q <= 1'b0;
    end
    else
    begin
      proc_q   <= !proc_on(state_d, sw_d[0]);
      peri_q   <= !peri_on(state_d, sw_d, wpo_d);
      // clock stopped while user reset waits on the pin
      clk_en_q <= !((state_d == rst_mgr_pkg::st_user) && hold);
    end
  end

  // cause written only as the processor reset releases
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      cause_q <= rst_mgr_pkg::CA_GEN;
    end
    else if (!proc_q && !proc_on(state_d, sw_d[0]))
    begin
      unique case (state_q)
        rst_mgr_pkg::st_bkup: cause_q <= rst_mgr_pkg::CA_BKUP;
        rst_mgr_pkg::st_wdt:  cause_q <= rst_mgr_pkg::CA_WDT;
        rst_mgr_pkg::st_sw:   cause_q <= rst_mgr_pkg::CA_SW;
        rst_mgr_pkg::st_user: cause_q <= rst_mgr_pkg::CA_USER;
        default:              cause_q <= rst_mgr_pkg::CA_GEN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin manager: pulse length countdown
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      oe_q    <= 1'b1;
      pulse_q <= rst_mgr_pkg::PW'(1);
    end
    else if (ext_req)
    begin
      oe_q    <= 1'b1;
      pulse_q <= pulse_top(len_q);
    end
    else if (pulse_q != '0)
    begin
      pulse_q <= pulse_q - rst_mgr_pkg::PW'(1);
    end
    else
    begin
      oe_q    <= 1'b0;
    end
  end

  // our own low level must not look like a user reset
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      self_q <= 1'b1;
    end
    else if (oe_q)
    begin
      self_q <= 1'b1;
    end
    else if (s2_q)
    begin
      self_q <= 1'b0;
    end
  end

  // pin value is always low, only the enable moves
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pin_o_q <= 1'b0;
    end
    else
    begin
      pin_o_q <= 1'b0;
    end
  end

  // two-stage synchroniser plus edge history
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end
    else
    begin
      s1_q <= nrst_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // sticky fall flag, set beats the read clear
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      fall_q <= 1'b0;
    end
    else if (s3_q && !s2_q)
    begin
      fall_q <= 1'b1;
    end
    else if (rd_stat)
    begin
      fall_q <= 1'b0;
    end
  end

  // interrupt when user reset disabled and enabled here
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= fall_q && ien_q && !uen_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // mode register, set to reset values only by the general reset
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      uen_q <= rst_mgr_pkg::UEN_RST;
      ien_q <= rst_mgr_pkg::IEN_RST;
      len_q <= rst_mgr_pkg::LEN_RST;
    end
    else if (wr_en && (addr == rst_mgr_pkg::ADDR_MODE))
    begin
      uen_q <= wdata[rst_mgr_pkg::M_UEN];
      ien_q <= wdata[rst_mgr_pkg::M_IEN];
      len_q <= wdata[rst_mgr_pkg::M_LEN +: 4];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      rdata_q <= 32'h0;
    end
    else
    begin
      rdata_q <= 32'h0;
      if (rd_stat)
      begin
        rdata_q[rst_mgr_pkg::S_FALL]     <= fall_q;
        rdata_q[rst_mgr_pkg::S_CAUSE +: 3] <= cause_q;
        rdata_q[rst_mgr_pkg::S_LEVEL]    <= s2_q;
        rdata_q[rst_mgr_pkg::S_BUSY]     <= (state_q == rst_mgr_pkg::st_sw);
      end
      else if (rd_en && (addr == rst_mgr_pkg::ADDR_MODE))
      begin
        rdata_q[rst_mgr_pkg::M_UEN]    <= uen_q;
        rdata_q[rst_mgr_pkg::M_IEN]    <= ien_q;
        rdata_q[rst_mgr_pkg::M_LEN +: 4] <= len_q;
      end
    end
  end

  // outputs straight from flip-flops
  assign rdata        = rdata_q;
  assign nrst_o       = pin_o_q;
  assign nrst_oe      = oe_q;
  assign proc_rst_b   = proc_q;
  assign periph_rst_b = peri_q;
  assign proc_clk_en  = clk_en_q;
  assign user_irq     = irq_q;

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_pulse_min: assert property (
    $fell(oe_q) |-> $past(oe_q, 2))
    else $error("pin pulse shorter than two cycles");
  a_user_off: assert property (
    (state_q == rst_mgr_pkg::st_idle && !uen_q) |=> state_q != rst_mgr_pkg::st_user)
    else $error("user reset while disabled");
  a_user_both: assert property (
    (state_q == rst_mgr_pkg::st_user) |-> !proc_q && !peri_q)
    else $error("user reset not asserting both resets");
  a_user_code: assert property (
    ($rose(proc_q) && $past(state_q == rst_mgr_pkg::st_user)) |-> cause_q == rst_mgr_pkg::CA_USER)
    else $error("user cause code wrong");
  a_cause_time: assert property (
    $changed(cause_q) |-> $rose(proc_q))
    else $error("cause changed outside release");
  a_sw_len: assert property (
    ($fell(state_q == rst_mgr_pkg::st_sw) && state_q == rst_mgr_pkg::st_idle)
      |-> $past(state_q == rst_mgr_pkg::st_sw, 3))
    else $error("software reset too short");
  a_wdt_len: assert property (
    ($fell(state_q == rst_mgr_pkg::st_wdt) && state_q == rst_mgr_pkg::st_idle)
      |-> $past(state_q == rst_mgr_pkg::st_wdt, 3) && !$past(state_q == rst_mgr_pkg::st_wdt, 4))
    else $error("watchdog reset length wrong");
  a_key_check: assert property (
    $rose(state_q == rst_mgr_pkg::st_sw)
      |-> $past(wdata[rst_mgr_pkg::KEY_LSB +: 8] == rst_mgr_pkg::CMD_KEY && wr_en))
    else $error("command taken without key");
  a_fall_keep: assert property (
    (fall_q && !rd_stat) |=> fall_q)
    else $error("fall flag lost without read");
  a_pin_level: assert property (
    rd_stat |=> rdata_q[rst_mgr_pkg::S_LEVEL] == $past(s2_q))
    else $error("level bit wrong");
  a_pin_hold: assert property (
    (state_q == rst_mgr_pkg::st_user && !s2_q) |=> !proc_q)
    else $error("released while pin low");
  a_bkup_first: assert property (
    (backup_wake && state_q == rst_mgr_pkg::st_idle) |=> state_q == rst_mgr_pkg::st_bkup)
    else $error("backup not taken first");

  c_user: cover property ($rose(proc_q) && cause_q == rst_mgr_pkg::CA_USER);
  c_sw: cover property ($fell(state_q == rst_mgr_pkg::st_sw));
  c_wdt_pre: cover property (state_q == rst_mgr_pkg::st_sw ##1 state_q == rst_mgr_pkg::st_wdt);
  c_irq: cover property ($rose(irq_q));

endmodule

// *** verification/pin_button_model.sv ***
// push-button with a slow external supervisor on the reset pin
// assumes the bench resolves the pin with a pull-up from every drive enable
`timescale 1ns/1ps
module pin_button_model (
  // clock
  input  wire logic       mclk,
  // control from the bench
  input  wire logic       press,
  input  wire logic [7:0] stretch,
  // pin drive, high while pulling low
  output logic            hold_oe
);
  logic [7:0] left_q = 8'h00; // extra hold cycles still to run
  ////////////////////////////////////////
  // keeps the pin low after the button lets go, like a slow supervisor
  always_ff @(posedge mclk)
  begin
    if (press)
      left_q <= stretch;
    else if (left_q != 8'h00)
      left_q <= left_q - 8'h01;
  end
  // pulls low while pressed and while the supervisor holds on
  assign hold_oe = press | (left_q != 8'h00);
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the reset manager
// assumes one 40 MHz clock and a pull-up on the reset pin
`timescale 1ns/1ps
module testbench;
  ////////////////////////////////////////
  // stimulus and observed signals
  logic        mclk = 1'b0;
  logic        rst_b;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rdata;
  logic        backup_wake;
  logic        wdt_fault;
  logic        wdt_proc_only;
  wire         nrst_i;
  logic        nrst_o;
  logic        nrst_oe;
  logic        proc_rst_b;
  logic        periph_rst_b;
  logic        proc_clk_en;
  logic        user_irq;
  logic        press;
  logic [7:0]  stretch;
  logic        btn_oe;
  int          error_cnt = 0;
  int          checked = 0;
  int          n_proc = 0;      // cycles with processor reset low
  int          n_peri = 0;      // cycles with peripheral reset low
  int          n_oe = 0;        // cycles with the pin driven
  int          p0, q0, o0;      // counter snapshots
  logic [31:0] d;               // last read data
  localparam logic [3:0] cm_a = rst_mgr_pkg::ADDR_CMD;
  localparam logic [3:0] st_a = rst_mgr_pkg::ADDR_STAT;
  localparam logic [3:0] md_a = rst_mgr_pkg::ADDR_MODE;
  always #12.5 mclk = ~mclk;
  // pin is pulled up unless a party pulls it low
  assign nrst_i = ((nrst_oe & ~nrst_o) | btn_oe) ? 1'b0 : 1'b1;
  system_reset_manager dut_u (
    .mclk          (mclk),
    .rst_b         (rst_b),
    .addr          (addr),
    .wdata         (wdata),
    .wr_en         (wr_en),
    .rd_en         (rd_en),
    .rdata         (rdata),
    .backup_wake   (backup_wake),
    .wdt_fault     (wdt_fault),
    .wdt_proc_only (wdt_proc_only),
    .nrst_i        (nrst_i),
    .nrst_o        (nrst_o),
    .nrst_oe       (nrst_oe),
    .proc_rst_b    (proc_rst_b),
    .periph_rst_b  (periph_rst_b),
    .proc_clk_en   (proc_clk_en),
    .user_irq      (user_irq)
  );
  pin_button_model btn_u (
    .mclk    (mclk),
    .press   (press),
    .stretch (stretch),
    .hold_oe (btn_oe)
  );
  ////////////////////////////////////////
  // cycle counters for reset and pin lengths
  always @(posedge mclk)
  begin
    n_proc <= n_proc + int'(proc_rst_b === 1'b0);
    n_peri <= n_peri + int'(periph_rst_b === 1'b0);
    n_oe   <= n_oe + int'(nrst_oe === 1'b1);
  end
  ////////////////////////////////////////
  // compare, bus and helper tasks
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_n(input string what, input int e, input int g);
    checked++;
    if (g != e)
    begin
      error_cnt++;
      $display("FAIL %s expected %0d seen %0d", what, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic snap;
    #1;
    p0 = n_proc;
    q0 = n_peri;
    o0 = n_oe;
  endtask
  task automatic counts(input string s, input int ep, input int eq, input int eo);
    #1;
    chk_n({s, " proc"}, ep, n_proc - p0);
    chk_n({s, " periph"}, eq, n_peri - q0);
    chk_n({s, " pin"}, eo, n_oe - o0);
  endtask
  task automatic cause_is(input logic [2:0] e);
    rd(st_a);
    chk("cause", {29'h0, e}, {29'h0, d[10:8]});
  endtask
  // waits, bounded, for both resets to run, then lets the pin settle
  task automatic wait_run;
    int i;
    for (i = 0; i < 100 && !(proc_rst_b === 1'b1 && periph_rst_b === 1'b1); i++)
      @(posedge mclk);
    chk("run", 32'h1, {31'h0, proc_rst_b & periph_rst_b});
    repeat (20) @(posedge mclk);
  endtask
  task automatic fault(input logic only);
    @(posedge mclk);
    wdt_proc_only <= only;
    wdt_fault     <= 1'b1;
    @(posedge mclk);
    wdt_fault <= 1'b0;
  endtask
  ////////////////////////////////////////
  // scenarios
  task automatic t_power;
    snap;
    wait_run;
    #1;
    chk_n("power pin", 2, n_oe - o0);
    rd(md_a);
    chk("mode reset", 32'h0000_0001, d);
    rd(st_a);
    chk("status reset", 32'h0001_0000, d & 32'h0003_0700);
    rd(4'hc);
    chk("unmapped", 32'h0, d);
    $display("power-up done");
  endtask
  task automatic t_sw;
    wr(md_a, 32'h0000_0201);
    snap;
    wr(cm_a, 32'h5a00_000d);
    repeat (10) @(posedge mclk);
    counts("bad key", 0, 0, 0);
    snap;
    wr(cm_a, 32'ha500_000d);
    rd(st_a);
    chk("busy old cause", 32'h0002_0000, d & 32'h0002_0700);
    wait_run;
    counts("software", 3, 3, 8);
    rd(st_a);
    chk("software status", 32'h0000_0300, d & 32'h0002_0700);
    rd(md_a);
    chk("mode kept", 32'h0000_0201, d);
    $display("software reset done");
  endtask
  task automatic t_user;
    int k;
    wr(md_a, 32'h0000_0001);
    rd(st_a);
    snap;
    @(posedge mclk);
    press <= 1'b1;
    repeat (30) @(posedge mclk);
    rd(st_a);
    chk("held status", 32'h0000_0001, d & 32'h0001_0001);
    chk("held resets", 32'h0, {29'h0, proc_rst_b, periph_rst_b, proc_clk_en});
    chk_n("user pin", 2, n_oe - o0);
    @(posedge mclk);
    press <= 1'b0;
    repeat (15) @(posedge mclk);
    chk("stretched", 32'h0, {31'h0, proc_rst_b});
    for (k = 0; k < 40 && nrst_i !== 1'b1; k++)
      @(posedge mclk);
    for (k = 0; k < 20 && proc_rst_b !== 1'b1; k++)
      @(posedge mclk);
    chk_n("release delay", 1, int'(k >= 4 && k <= 7));
    repeat (20) @(posedge mclk);
    rd(st_a);
    chk("user status", 32'h0001_0400, d & 32'h0001_0701);
    chk("clock back", 32'h1, {31'h0, proc_clk_en});
    $display("user reset done");
  endtask
  task automatic t_len;
    for (int k = 0; k < 4; k++)
    begin
      wr(md_a, {20'h0, 4'(k), 8'h01});
      snap;
      wr(cm_a, 32'ha500_0008);
      repeat (40) @(posedge mclk);
      counts("pin only", 0, 0, 2 << k);
    end
    cause_is(3'h4);
    $display("pulse lengths done");
  endtask
  task automatic t_irq;
    wr(md_a, 32'h0000_0010);
    rd(st_a);
    snap;
    @(posedge mclk);
    press <= 1'b1;
    repeat (10) @(posedge mclk);
    press <= 1'b0;
    repeat (30) @(posedge mclk);
    counts("irq mode", 0, 0, 0);
    chk("irq", 32'h1, {31'h0, user_irq});
    rd(st_a);
    chk("fall seen", 32'h1, d & 32'h1);
    repeat (3) @(posedge mclk);
    chk("irq cleared", 32'h0, {31'h0, user_irq});
    $display("interrupt done");
  endtask
  task automatic t_wdt;
    wr(md_a, 32'h0000_0101);
    snap;
    fault(1'b0);
    rd(st_a);
    chk("cause on entry", 32'h4, {29'h0, d[10:8]});
    wait_run;
    counts("watchdog", 3, 3, 4);
    cause_is(rst_mgr_pkg::CA_WDT);
    snap;
    fault(1'b1);
    wait_run;
    counts("watchdog proc only", 3, 0, 0);
    $display("watchdog done");
  endtask
  task automatic t_prio;
    wr(cm_a, 32'ha500_0005);
    fault(1'b0);
    wait_run;
    cause_is(rst_mgr_pkg::CA_WDT);
    snap;
    @(posedge mclk);
    backup_wake <= 1'b1;
    wdt_fault   <= 1'b1;
    @(posedge mclk);
    backup_wake <= 1'b0;
    wdt_fault   <= 1'b0;
    wait_run;
    cause_is(rst_mgr_pkg::CA_BKUP);
    $display("priority done");
  endtask
  ////////////////////////////////////////
  // verdict
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial
  begin
    rst_b = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    backup_wake = 1'b0;
    wdt_fault = 1'b0;
    wdt_proc_only = 1'b0;
    press = 1'b0;
    stretch = 8'h14;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    t_power;
    t_sw;
    t_user;
    t_len;
    t_irq;
    t_wdt;
    t_prio;
    test_done;
  end
  // watchdog against a hang
  initial
  begin
    repeat (6000) @(posedge mclk);
    error_cnt++;
    test_done;
  end
endmodule
